// File: rlsd_decoder.v
// Return and loop setup decoder: executes the transfer jump (relative or indirect target), returns and loop setups.
// Assumes one AHB-Lite master; condition results and register values come in on the bus.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rlsd_defs.vh"
module rlsd_decoder
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg compute_en,
    output reg dm_access,
    output reg dm_write,
    output reg [3:0] reg_file_sel,
    output reg [23:0] next_pc,
    output reg delayed,
    output reg status_pop
);
    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [31:0] ctrl_q;
    reg [31:0] instr_lo_q;
    reg [15:0] instr_hi_q;
    reg [23:0] pc_q;
    reg [31:0] ureg_q;
    reg [31:0] test_condition_field_q;
    reg [31:0] daddr_q;
    reg [15:0] latch_q;
    reg [15:0] maskp_q;
    reg [15:0] loop_count_register_q;
    reg [23:0] loop_end_q;
    reg [23:0] target_q;
    reg [31:0] status_q;
    reg [23:0] pc_stk_q [0:`RLSD_STK_DEPTH-1];
    reg [28:0] loop_stk_q [0:`RLSD_STK_DEPTH-1];
    reg [15:0] lc_stk_q [0:`RLSD_STK_DEPTH-1];
    reg [`RLSD_PTR_W-1:0] pc_sp_q;
    reg [`RLSD_PTR_W-1:0] loop_sp_q;
    reg [`RLSD_PTR_W-1:0] lc_sp_q;
    reg reentry_q;
    wire [47:0] instr = {instr_hi_q, instr_lo_q};
    wire addr_ph = hsel & htrans[1] & hready;
    wire go = wr_pend_q && (wr_addr_q == `RLSD_REG_CTRL) && hwdata[`RLSD_CTRL_GO];
    wire [15:0] curlc = (lc_sp_q == 0) ? 16'h0000 : lc_stk_q[lc_sp_q - 3'h1];
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ph && !hwrite)
            begin
                case (haddr[7:0])
                    `RLSD_REG_CTRL: hrdata <= ctrl_q;
                    `RLSD_REG_INSTR_LO: hrdata <= instr_lo_q;
                    `RLSD_REG_INSTR_HI: hrdata <= {16'h0000, instr_hi_q};
                    `RLSD_REG_PC: hrdata <= {8'h00, pc_q};
                    `RLSD_REG_STATUS: hrdata <= status_q;
                    `RLSD_REG_TARGET: hrdata <= {8'h00, target_q};
                    `RLSD_REG_LOOP_COUNT_REGISTER: hrdata <= {16'h0000, loop_count_register_q};
                    `RLSD_REG_CURLC: hrdata <= {16'h0000, curlc};
                    `RLSD_REG_LOOPEND: hrdata <= {8'h00, loop_end_q};
                    `RLSD_REG_LATCH: hrdata <= {maskp_q, latch_q};
                    `RLSD_REG_UREG: hrdata <= ureg_q;
                    `RLSD_REG_TEST_CONDITION_FIELD: hrdata <= test_condition_field_q;
                    `RLSD_REG_DADDR: hrdata <= daddr_q;
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Bits 47:46 mark the transfer jump; bit 45 picks the relative target over the indirect one
    wire is_t10 = (instr[47:46] == 2'b11);
    wire [7:0] grp = instr[47:40];
    wire is_rts = (grp == `RLSD_OP_RTS);
    wire is_rti = (grp == `RLSD_OP_RTI);
    wire is_dolc = (grp == `RLSD_OP_DOLC_IMM) || (grp == `RLSD_OP_DOLC_UREG);
    wire is_dou = (grp == `RLSD_OP_DOUNTIL);
    wire [4:0] cnd = is_t10 ? instr[37:33] : instr[37:33];
    wire test_condition_field_true = (cnd == `RLSD_TEST_CONDITION_FIELD_TRUE) | test_condition_field_q[cnd];
    wire else_bit = instr[25];
    wire [23:0] rel6 = {{18{instr[32]}}, instr[32:27]};
    wire [23:0] rel24 = instr[23:0];
    wire [3:0] stat_irq = status_q[3:0];
    // ------------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------------
    integer i;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= 32'h0000_0000;
            instr_lo_q <= 32'h0000_0000;
            instr_hi_q <= 16'h0000;
            pc_q <= 24'h000000;
            ureg_q <= 32'h0000_0000;
            test_condition_field_q <= 32'h0000_0000;
            daddr_q <= 32'h0000_0000;
            latch_q <= 16'h0000;
            maskp_q <= 16'h0000;
            loop_count_register_q <= 16'h0000;
            loop_end_q <= 24'h000000;
            target_q <= 24'h000000;
            status_q <= 32'h0000_0000;
            pc_sp_q <= 3'h0;
            loop_sp_q <= 3'h0;
            lc_sp_q <= 3'h0;
            reentry_q <= 1'b0;
            compute_en <= 1'b0;
            dm_access <= 1'b0;
            dm_write <= 1'b0;
            reg_file_sel <= 4'h0;
            next_pc <= 24'h000000;
            delayed <= 1'b0;
            status_pop <= 1'b0;
            for (i = 0; i < `RLSD_STK_DEPTH; i = i + 1)
            begin
                pc_stk_q[i] <= 24'h000000;
                loop_stk_q[i] <= 29'h00000000;
                lc_stk_q[i] <= 16'h0000;
            end
        end
        else
        begin
            compute_en <= 1'b0;
            dm_access <= 1'b0;
            status_pop <= 1'b0;
            if (wr_pend_q)
            begin
                case (wr_addr_q)
                    `RLSD_REG_INSTR_LO: instr_lo_q <= hwdata;
                    `RLSD_REG_INSTR_HI: instr_hi_q <= hwdata[15:0];
                    `RLSD_REG_PC: pc_q <= hwdata[23:0];
                    `RLSD_REG_LATCH:
                    begin
                        latch_q <= hwdata[15:0];
                        maskp_q <= hwdata[31:16];
                    end
                    `RLSD_REG_UREG: ureg_q <= hwdata;
                    `RLSD_REG_TEST_CONDITION_FIELD: test_condition_field_q <= hwdata;
                    `RLSD_REG_DADDR: daddr_q <= hwdata;
                    `RLSD_REG_STATUS: status_q <= hwdata;
                    `RLSD_REG_CURLC:
                    begin
                        // Loop-tail test: skip one decrement after a reentry return set reentry_q; otherwise decrement unless zero
                        if (reentry_q)
                            reentry_q <= 1'b0;
                        else if (lc_sp_q != 0 && curlc != 16'h0000)
                            lc_stk_q[lc_sp_q - 3'h1] <= curlc - 16'h0001;
                    end
                    default: ctrl_q <= hwdata;
                endcase
            end
            if (go)
            begin
                next_pc <= pc_q + 24'h000001;
                delayed <= 1'b0;
                if (is_t10)
                begin
                    // Data index in daddr[15:0], modify in daddr[31:16], branch regs in ureg
                    if (test_condition_field_true)
                    begin
                        target_q <= instr[45] ? (pc_q + rel6)
                            : (ureg_q[23:0] + {8'h00, ureg_q[31:16]});
                        next_pc <= instr[45] ? (pc_q + rel6)
                            : (ureg_q[23:0] + {8'h00, ureg_q[31:16]});
                    end
                    else
                    begin
                        dm_access <= 1'b1;
                        dm_write <= instr[44];
                        reg_file_sel <= instr[26:23];
                        target_q <= {8'h00, daddr_q[15:0]};
                        daddr_q[15:0] <= daddr_q[15:0] + daddr_q[31:16];
                        compute_en <= (instr[22:0] != 23'h000000);
                    end
                end
                else if (is_rts || is_rti)
                begin
                    compute_en <= (instr[22:0] != 23'h000000) && (else_bit ? !test_condition_field_true : test_condition_field_true);
                    if (test_condition_field_true && pc_sp_q != 0)
                    begin
                        next_pc <= pc_stk_q[pc_sp_q - 3'h1];
                        target_q <= pc_stk_q[pc_sp_q - 3'h1];
                        pc_sp_q <= pc_sp_q - 3'h1;
                    end
                    // Status and latch side effects do not depend on the PC stack holding an entry
                    if (test_condition_field_true)
                    begin
                        delayed <= instr[26];
                        if (is_rts)
                            reentry_q <= instr[24];
                        else
                        begin
                            status_pop <= status_q[4];
                            latch_q[stat_irq] <= 1'b0;
                            maskp_q[stat_irq] <= 1'b0;
                        end
                    end
                    // False condition keeps sequential next_pc
                end
                else if (is_dolc || is_dou)
                begin
                    loop_end_q <= pc_q + rel24;
                    if (pc_sp_q != `RLSD_STK_DEPTH)
                    begin
                        pc_stk_q[pc_sp_q] <= pc_q + 24'h000001;
                        pc_sp_q <= pc_sp_q + 3'h1;
                    end
                    if (loop_sp_q != `RLSD_STK_DEPTH)
                    begin
                        loop_stk_q[loop_sp_q] <= {is_dolc ? `RLSD_TEST_CONDITION_FIELD_LCE : instr[37:33],
                            pc_q + rel24};
                        loop_sp_q <= loop_sp_q + 3'h1;
                    end
                    if (is_dolc && lc_sp_q != `RLSD_STK_DEPTH)
                    begin
                        loop_count_register_q <= grp[0] ? ureg_q[15:0] : instr[39:24];
                        lc_stk_q[lc_sp_q] <= grp[0] ? ureg_q[15:0] : instr[39:24];
                        lc_sp_q <= lc_sp_q + 3'h1;
                    end
                end
            end
        end
    end
endmodule

// File: rlsd_defs.vh
// Constants for the return and loop setup decoder: opcode fields, codes, register map.
// Assumes a 48-bit instruction word and a 100 MHz core clock.
`ifndef RLSD_DEFS_VH
`define RLSD_DEFS_VH
`define RLSD_REG_CTRL 8'h00
`define RLSD_REG_INSTR_LO 8'h04
`define RLSD_REG_INSTR_HI 8'h08
`define RLSD_REG_PC 8'h0c
`define RLSD_REG_STATUS 8'h10
`define RLSD_REG_TARGET 8'h14
`define RLSD_REG_LOOP_COUNT_REGISTER 8'h18
`define RLSD_REG_CURLC 8'h1c
`define RLSD_REG_LOOPEND 8'h20
`define RLSD_REG_LATCH 8'h24
`define RLSD_REG_UREG 8'h28
`define RLSD_REG_TEST_CONDITION_FIELD 8'h2c
`define RLSD_REG_DADDR 8'h30
`define RLSD_CTRL_GO 0
`define RLSD_OP_T10 3'b111
`define RLSD_OP_RTS 8'h0a
`define RLSD_OP_RTI 8'h0b
`define RLSD_OP_DOLC_IMM 8'h0c
`define RLSD_OP_DOLC_UREG 8'h0d
`define RLSD_OP_DOUNTIL 8'h0e
`define RLSD_TEST_CONDITION_FIELD_LCE 5'h0f
`define RLSD_TEST_CONDITION_FIELD_TRUE 5'h1f
`define RLSD_STK_DEPTH 6
`define RLSD_PTR_W 3
`define RLSD_IRQ_BITS 16
`endif

// File: rlsd_decoder_props.sv
// Checker for the return and loop setup decoder, bound to its top module.
// Assumes zero-wait AHB-Lite writes; it shadows instruction, pc, status and condition registers.
`timescale 1ns/1ps
`include "rlsd_defs.vh"
module rlsd_decoder_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic compute_en,
    input wire logic dm_access,
    input wire logic dm_write,
    input wire logic [3:0] reg_file_sel,
    input wire logic [23:0] next_pc,
    input wire logic delayed,
    input wire logic status_pop
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
// ----------------------------------------
// Register shadows
// ----------------------------------------
logic [7:0] a_q;
logic w_q;
logic [31:0] lo_q, hi_q, pc_q, st_q, cd_q;
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        a_q <= 8'h00; w_q <= 1'b0; lo_q <= 32'h0; hi_q <= 32'h0; pc_q <= 32'h0; st_q <= 32'h0; cd_q <= 32'h0;
    end
    else
    begin
        a_q <= haddr[7:0];
        w_q <= hsel && htrans[1] && hready && hwrite;
        if (w_q && a_q == `RLSD_REG_INSTR_LO) lo_q <= hwdata;
        if (w_q && a_q == `RLSD_REG_INSTR_HI) hi_q <= hwdata;
        if (w_q && a_q == `RLSD_REG_PC) pc_q <= hwdata;
        if (w_q && a_q == `RLSD_REG_STATUS) st_q <= hwdata;
        if (w_q && a_q == `RLSD_REG_TEST_CONDITION_FIELD) cd_q <= hwdata;
    end
end
wire [47:0] ins = {hi_q[15:0], lo_q};
wire go = w_q && a_q == `RLSD_REG_CTRL && hwdata[0];
wire t10 = ins[47:45] == `RLSD_OP_T10;
wire interrupt_return = ins[47:40] == `RLSD_OP_RTI;
wire ret = interrupt_return || ins[47:40] == `RLSD_OP_RTS;
wire ct = ins[37:33] == `RLSD_TEST_CONDITION_FIELD_TRUE || cd_q[ins[37:33]];
wire cmp = |ins[22:0];
wire [23:0] rel_tgt = pc_q[23:0] + {{18{ins[32]}}, ins[32:27]};
wire cmp_exp = cmp && (ins[25] ? !ct : ct);
property p_rel; go && t10 && ct |=> next_pc == $past(rel_tgt) && !dm_access; endproperty
property p_dm; go && t10 && !ct |=> dm_access && dm_write == $past(ins[44]) && reg_file_sel == $past(ins[26:23]); endproperty
property p_cmp10; go && t10 |=> compute_en == $past(cmp && !ct); endproperty
property p_delay; go && ret && ct |=> delayed == $past(ins[26]); endproperty
property p_false; go && ret && !ct |=> next_pc == $past(pc_q[23:0]) + 24'h1 && !status_pop; endproperty
property p_else; go && ret |=> compute_en == $past(cmp_exp); endproperty
property p_pop; go && interrupt_return && ct && st_q[4] |=> status_pop ##1 !status_pop; endproperty
property p_rtsnopop; go && !interrupt_return |=> !status_pop; endproperty
a_rel: assert property (p_rel) else $error("relative jump target wrong");
a_dm: assert property (p_dm) else $error("data transfer fields wrong");
a_cmp10: assert property (p_cmp10) else $error("transfer compute wrong");
a_delay: assert property (p_delay) else $error("return delay flag wrong");
a_false: assert property (p_false) else $error("false return not sequential");
a_else: assert property (p_else) else $error("return compute wrong");
a_pop: assert property (p_pop) else $error("status pop missing");
a_rtsnopop: assert property (p_rtsnopop) else $error("status popped without interrupt return");
c_rel: cover property (go && t10 && ct);
c_rti: cover property (go && interrupt_return && ct);
c_retf: cover property (go && ret && !ct);
endmodule

// File: tb_return_and_loop_setup_decode.sv
// Self-checking bench for the return and loop setup decoder.
// Assumes the design and its defines header are compiled alongside.
`timescale 1ns/1ps
`include "rlsd_defs.vh"
module tb_return_and_loop_setup_decode;
logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
logic [31:0] haddr = 32'h0, hwdata = 32'h0;
logic [1:0] htrans = 2'b00;
logic [2:0] hsize = 3'b010;
wire hready, hreadyout, hresp, compute_en, dm_access, dm_write, delayed, status_pop;
wire [31:0] hrdata;
wire [3:0] reg_file_sel;
wire [23:0] next_pc;
int errors = 0;
int checked = 0;
assign hready = hreadyout;
rlsd_decoder dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .compute_en, .dm_access, .dm_write, .reg_file_sel, .next_pc, .delayed, .status_pop);
initial forever #5 hclk = ~hclk;
// ----------------------------------------
// Bus and check tasks
// ----------------------------------------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
        errors++;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
endtask
task automatic exec(input logic [47:0] i, input logic [23:0] p);
    logic [31:0] r;
    bus(1'b1, `RLSD_REG_INSTR_LO, i[31:0], r);
    bus(1'b1, `RLSD_REG_INSTR_HI, {16'h0, i[47:32]}, r);
    bus(1'b1, `RLSD_REG_PC, {8'h0, p}, r);
    bus(1'b1, `RLSD_REG_CTRL, 32'h1, r);
    #1;
endtask
function automatic logic [47:0] mk(input logic [7:0] op, input logic [4:0] c, input logic [2:0] jel);
    mk = {op, 2'b00, c, 6'h00, jel, 24'h0};
endfunction
task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
initial
begin
    #400000;
    errors++;
    tally_and_finish;
end
initial
begin
    logic [31:0] r, cd;
    logic [47:0] ins;
    logic [23:0] p, cnt, rel;
    int k;
    logic ct;
    void'($urandom(47));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
        p = 24'h100 + 24'(v * 16'h40); cnt = 24'h5 + 24'(v); rel = v ? 24'hfffff0 : 24'h000010;
        bus(1'b1, `RLSD_REG_UREG, {16'h0, cnt[15:0]}, r);
        exec({v ? `RLSD_OP_DOLC_UREG : `RLSD_OP_DOLC_IMM, v ? 16'h0 : cnt[15:0], rel}, p);
        bus(1'b0, `RLSD_REG_LOOP_COUNT_REGISTER, 32'h0, r); chk({16'h0, r[15:0]}, {8'h0, cnt});
        bus(1'b0, `RLSD_REG_CURLC, 32'h0, r); chk({16'h0, r[15:0]}, {8'h0, cnt});
        bus(1'b0, `RLSD_REG_LOOPEND, 32'h0, r); chk({8'h0, r[23:0]}, {8'h0, p + rel});
        bus(1'b1, `RLSD_REG_CURLC, 32'h0, r);
        bus(1'b0, `RLSD_REG_CURLC, 32'h0, r); chk({16'h0, r[15:0]}, {8'h0, cnt - 24'h1});
        exec(mk(`RLSD_OP_RTS, `RLSD_TEST_CONDITION_FIELD_TRUE, 3'b001), 24'h0);
        chk({8'h0, next_pc}, {8'h0, p + 24'h1});
        bus(1'b1, `RLSD_REG_CURLC, 32'h0, r);
        bus(1'b0, `RLSD_REG_CURLC, 32'h0, r); chk({16'h0, r[15:0]}, {8'h0, cnt - 24'h1});
        $display("loop setup test %0d done", v);
    end
    for (int n = 0; n < 16; n += 5)
    begin
        p = 24'h300 + 24'(n);
        exec(mk(`RLSD_OP_DOUNTIL, 5'h03, 3'b000) | 48'h10, p);
        bus(1'b1, `RLSD_REG_STATUS, 32'h10 | 32'(n), r);
        bus(1'b1, `RLSD_REG_LATCH, 32'hffffffff, r);
        exec(mk(`RLSD_OP_RTI, `RLSD_TEST_CONDITION_FIELD_TRUE, 3'b000), 24'h0);
        chk(32'(status_pop), 32'h1);
        chk({8'h0, next_pc}, {8'h0, p + 24'h1});
        bus(1'b0, `RLSD_REG_LATCH, 32'h0, r); chk({30'h0, r[16 + n], r[n]}, 32'h0);
    end
    bus(1'b0, 8'h40, 32'h0, r); chk(r, 32'h0);
    $display("interrupt return test done");
    for (int t = 0; t < 60; t++)
    begin
        k = $urandom % 3; p = 24'($urandom); cd = $urandom;
        ins[31:0] = $urandom; ins[47:32] = 16'($urandom);
        if (k == 0) ins[47:45] = `RLSD_OP_T10;
        else ins[47:38] = {k == 1 ? `RLSD_OP_RTS : `RLSD_OP_RTI, 2'b00};
        if ($urandom % 4 == 0) ins[37:33] = `RLSD_TEST_CONDITION_FIELD_TRUE;
        if (k > 0 && ins[25] && ins[37:33] == `RLSD_TEST_CONDITION_FIELD_TRUE) ins[37:33] = 5'h02;
        bus(1'b1, `RLSD_REG_TEST_CONDITION_FIELD, cd, r);
        exec(ins, p);
        ct = ins[37:33] == `RLSD_TEST_CONDITION_FIELD_TRUE || cd[ins[37:33]];
        if (k == 0 && ct) chk({8'h0, next_pc}, {8'h0, p + {{18{ins[32]}}, ins[32:27]}});
        if (k == 0 && !ct) chk({31'h0, dm_access}, 32'h1);
        if (k == 0 && !ct) chk({31'h0, dm_write}, {31'h0, ins[44]});
        if (k == 0 && !ct) chk({28'h0, reg_file_sel}, {28'h0, ins[26:23]});
        if (k > 0 && !ct) chk({8'h0, next_pc}, {8'h0, p + 24'h1});
        if (k > 0 && ct) chk(32'(delayed), 32'(ins[26]));
        chk(32'(compute_en), 32'(|ins[22:0] && (k == 0 || ins[25] ? !ct : ct)));
    end
    $display("random test done");
    tally_and_finish;
end
endmodule
bind rlsd_decoder rlsd_decoder_props props_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .compute_en, .dm_access, .dm_write, .reg_file_sel, .next_pc, .delayed,
    .status_pop);
